// ===== hdl/shp_params.svh
// shp_params.svh - constants of the sram-like host port
// assumes: included by the package and the bench files by bare name
`ifndef SHP_PARAMS_SVH
`define SHP_PARAMS_SVH
`define SHP_HW          16
`define SHP_WW          32
`define SHP_AW          7
`define SHP_NREG        32
`define SHP_IDX_W       5
`define SHP_QSEL_HI     6
`define SHP_QSEL_LO     2
`define SHP_IRQ_CFG_IDX 5'h15
`define SHP_IRQ_STS_IDX 5'h16
`define SHP_IRQ_EN_IDX  5'h17
`define SHP_IRQ_POL_BIT 4
`define SHP_IRQ_OD_BIT  0
`define SHP_IRQ_SRC_W   8
`define SHP_IRQ_SRC_OFS 0
`endif

// ===== hdl/shp_pkg.sv
// shp_pkg.sv - types shared by the host port files
// assumes: shp_params.svh is on the include path
`include "shp_params.svh"
package shp_pkg;
    typedef struct packed {
        logic                 cs_n;
        logic                 rd_n;
        logic                 wr_n;
        logic                 qsel;
        logic [`SHP_AW-1:0]   addr;
        logic [`SHP_HW-1:0]   data;
    } shp_bus_t;

    typedef enum logic [2:0] {
        SHP_IDLE = 3'h1,
        SHP_RD   = 3'h2,
        SHP_WR   = 3'h4
    } shp_state_t;

    typedef struct packed {
        shp_state_t           st;
        logic                 armed;
        logic                 asleep;
        logic [`SHP_HW-1:0]   rd_data;
        logic                 drv_en;
        logic [`SHP_HW-1:0]   lo_half;
        logic                 irq;
        logic                 irq_oe;
        logic                 we;
        logic                 rqpush;
        logic                 txpush;
        logic [`SHP_IDX_W-1:0] widx;
        logic [`SHP_WW-1:0]   wdata;
        logic                 wake;
    } shp_top_t;
endpackage : shp_pkg

// ===== hdl/shp_regfile.sv
// shp_regfile.sv - 32-word register memory, registered read data
// assumes: single clock, one write and one read port
module shp_regfile
    import shp_pkg::*;
(
    input  wire logic                  clock_i,
    input  wire logic                  rst_b_i,
    input  wire logic                  we_i,
    input  wire logic [`SHP_IDX_W-1:0] widx_i,
    input  wire logic [`SHP_WW-1:0]    wdata_i,
    input  wire logic [`SHP_IDX_W-1:0] ridx_i,
    output logic      [`SHP_WW-1:0]    rdata_o
);
    logic [`SHP_WW-1:0] mem_q [`SHP_NREG];

    // storage cells, one per word
    genvar g;
    for (g = 0; g < `SHP_NREG; g++) begin : g_word
        always_ff @(posedge clock_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                mem_q[g] <= '0;
            end else if (we_i && widx_i == `SHP_IDX_W'(g)) begin
                mem_q[g] <= wdata_i;
            end
        end
    end

    // registered read so the port sees a flip-flop
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem_q[ridx_i];
        end
    end
endmodule : shp_regfile

// ===== hdl/shp_host_port.sv
// shp_host_port.sv - sram-like 16-bit host port of a network controller
// assumes: host pins are asynchronous and synchronised here; queue
// words leave on one-cycle pulses toward the core; sources are levels.
module shp_host_port
    import shp_pkg::*;
(
    input  wire logic                     clock_i,
    input  wire logic                     rst_b_i,
    input  wire logic                     port_select_n_i,
    input  wire logic                     read_strobe_n_i,
    input  wire logic                     write_strobe_n_i,
    input  wire logic                     queue_select_i,
    input  wire logic [`SHP_AW-1:0]       addr_i,
    input  wire logic [`SHP_HW-1:0]       data_i,
    output logic      [`SHP_HW-1:0]       data_o,
    output logic                          data_oe_o,
    input  wire logic                     sleep_req_i,
    input  wire logic [`SHP_WW-1:0]       rx_word_i,
    input  wire logic [`SHP_IRQ_SRC_W-1:0] irq_src_i,
    output logic                          rx_pop_o,
    output logic                          tx_push_o,
    output logic      [`SHP_WW-1:0]       tx_word_o,
    output logic                          wake_o,
    output logic                          asleep_o,
    output logic                          irq_o,
    output logic                          irq_oe_o
);
    shp_bus_t           s1_q, s2_q;    // two-stage pin synchroniser
    shp_top_t           st_q, st_d;
    logic [`SHP_WW-1:0] rf_rdata;
    logic [`SHP_WW-1:0] cfg_w, en_w;
    logic [`SHP_IDX_W-1:0] ridx;
    logic               hi_half, is_q, cyc_rd, cyc_wr, act;
    logic [`SHP_IRQ_SRC_W-1:0] hits;

    // pins pass two flops before any logic reads them
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
            s2_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
        end else begin
            s1_q <= '{port_select_n_i, read_strobe_n_i, write_strobe_n_i,
                      queue_select_i, addr_i, data_i};
            s2_q <= s1_q;
        end
    end

    // decode: qsel forces the queue port and drops the upper bits
    always_comb begin
        is_q    = s2_q.qsel;
        hi_half = s2_q.addr[0];
        ridx    = is_q ? '0
                       : s2_q.addr[`SHP_IDX_W:1];
        cyc_rd  = !s2_q.cs_n && !s2_q.rd_n;
        cyc_wr  = !s2_q.cs_n && !s2_q.wr_n;
        act     = cyc_rd || cyc_wr;
    end

    // irq config words live in the register memory, sampled via a copy
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_w <= '0;
            en_w  <= '0;
        end else begin
            if (st_q.we && st_q.widx == `SHP_IRQ_CFG_IDX) begin
                cfg_w <= st_q.wdata;
            end
            if (st_q.we && st_q.widx == `SHP_IRQ_EN_IDX) begin
                en_w <= st_q.wdata;
            end
        end
    end

    assign hits = irq_src_i
                  & en_w[`SHP_IRQ_SRC_OFS +: `SHP_IRQ_SRC_W];

    // one always_comb builds the whole next state
    always_comb begin
        logic [`SHP_HW-1:0] rd_half;
        logic               irq_act;
        irq_act     = |hits;
        rd_half     = '0;
        st_d        = st_q;
        st_d.we     = 1'b0;
        st_d.rqpush = 1'b0;
        st_d.txpush = 1'b0;
        st_d.wake   = 1'b0;
        rd_half = hi_half ? (is_q ? rx_word_i[`SHP_WW-1:`SHP_HW]
                                  : rf_rdata[`SHP_WW-1:`SHP_HW])
                          : (is_q ? rx_word_i[`SHP_HW-1:0]
                                  : rf_rdata[`SHP_HW-1:0]);
        if (sleep_req_i && !st_q.asleep) begin
            st_d.asleep = 1'b1;
            st_d.armed  = 1'b0;
        end
        case (st_q.st)
            SHP_IDLE: begin
                if (cyc_rd) begin
                    st_d.st = SHP_RD;
                end else if (cyc_wr) begin
                    st_d.st = SHP_WR;
                    if (st_q.asleep) begin
                        st_d.asleep = 1'b0;
                        st_d.wake   = 1'b1;
                        st_d.armed  = 1'b0;
                    end else if (st_q.armed) begin
                        if (!hi_half) begin
                            st_d.lo_half = s2_q.data;
                        end else begin
                            st_d.wdata = {s2_q.data, st_q.lo_half};
                            st_d.widx  = ridx;
                            st_d.txpush = is_q;
                            st_d.we    = !is_q;
                        end
                    end
                end
            end
            SHP_RD: begin
                st_d.rd_data = rd_half;
                st_d.drv_en  = cyc_rd;
                if (!cyc_rd) begin
                    st_d.st = SHP_IDLE;
                    st_d.armed  = !st_q.asleep;
                    st_d.rqpush = is_q && hi_half;
                end
            end
            SHP_WR: begin
                if (!act) begin
                    st_d.st = SHP_IDLE;
                end
            end
            default: begin
                st_d.st = SHP_IDLE;
            end
        endcase
        if (!cyc_rd) begin
            st_d.drv_en = 1'b0;
        end
        // polarity and open-drain from software config
        st_d.irq    = cfg_w[`SHP_IRQ_POL_BIT] ? irq_act : !irq_act;
        st_d.irq_oe = cfg_w[`SHP_IRQ_OD_BIT] ? irq_act : 1'b1;
    end

    // state register: all outputs come straight from here
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= '{st: SHP_IDLE, irq: 1'b0, irq_oe: 1'b1,
                      default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    shp_regfile u_regs (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .we_i    (st_q.we),
        .widx_i  (st_q.widx),
        .wdata_i (st_q.wdata),
        .ridx_i  (ridx),
        .rdata_o (rf_rdata)
    );

    assign data_o    = st_q.rd_data;
    assign data_oe_o = st_q.drv_en;
    assign rx_pop_o  = st_q.rqpush;
    assign tx_push_o = st_q.txpush;
    assign tx_word_o = st_q.wdata;
    assign wake_o    = st_q.wake;
    assign asleep_o  = st_q.asleep;
    assign irq_o     = st_q.irq;
    assign irq_oe_o  = st_q.irq_oe;
endmodule : shp_host_port

// ===== dv/shp_host_port_asserts.sv
// shp_host_port_asserts.sv - timing checks on the host port pins
// assumes: bound to shp_host_port, one clock, async low reset
module shp_host_port_asserts (
    input  wire logic clock_i,
    input  wire logic rst_b_i,
    input  wire logic port_select_n_i,
    input  wire logic read_strobe_n_i,
    input  wire logic write_strobe_n_i,
    input  wire logic queue_select_i,
    input  wire logic data_oe_o,
    input  wire logic tx_push_o,
    input  wire logic rx_pop_o,
    input  wire logic wake_o,
    input  wire logic asleep_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    logic rd_seen_q;
    // a read since reset or wake arms writes; cleared again by a wake
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) rd_seen_q <= 1'b0;
        else if (wake_o) rd_seen_q <= 1'b0;
        else if (data_oe_o) rd_seen_q <= 1'b1;
    end
    sequence s_wake_wr;
        asleep_o && !port_select_n_i && !write_strobe_n_i;
    endsequence
    // sync takes two edges, so the pins are looked at a few cycles back
    AST_OE_RISE: assert property ($rose(data_oe_o) |->
        $past(!port_select_n_i && !read_strobe_n_i, 3))
        else $error("data bus driven without a read");
    AST_OE_DROP: assert property (read_strobe_n_i [*4] |->
        !data_oe_o) else $error("data bus still driven");
    AST_TX_CAUSE: assert property (tx_push_o |->
        $past(!port_select_n_i && !write_strobe_n_i, 2))
        else $error("queue push without a write");
    AST_TX_QSEL: assert property (tx_push_o |->
        $past(queue_select_i, 2)) else $error("push outside queue mode");
    AST_WAKE: assert property (s_wake_wr ##1 s_wake_wr |->
        ##[0:6] wake_o) else $error("write did not wake");
    AST_RX_POP: assert property (rx_pop_o |->
        read_strobe_n_i) else $error("pop before read ended");
    AST_RST_IDLE: assert property ($rose(rst_b_i) |->
        !data_oe_o && !asleep_o) else $error("outputs busy after reset");
    AST_WR_AFTER_RD: assert property (tx_push_o |->
        rd_seen_q) else $error("write acted on before a read");
endmodule : shp_host_port_asserts

// ===== dv/shp_host_model.sv
// shp_host_model.sv - host processor driving the sram-like port pins
// assumes: one access at a time, caller keeps the clock running
`include "shp_params.svh"
module shp_host_model
    import shp_pkg::*;
(
    input  wire logic               clock_i,
    input  wire logic [`SHP_HW-1:0] data_i,
    output shp_bus_t                bus_o,
    output logic                    oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // strobes idle high, data released
    initial begin
        bus_o = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
        oe_o  = 1'b0;
    end
    // strobe held 6 cycles to cover the sync delay, then a 3 cycle gap
    task automatic acc(input logic w, input logic q,
                       input logic [`SHP_AW-1:0] a,
                       input logic [`SHP_HW-1:0] d,
                       output logic [`SHP_HW-1:0] r);
        @(posedge clock_i);
        bus_o.qsel <= q;
        bus_o.addr <= a;
        bus_o.data <= d;
        oe_o       <= w;
        bus_o.cs_n <= 1'b0;
        bus_o.rd_n <= w;
        bus_o.wr_n <= !w;
        repeat (6) @(posedge clock_i);
        r = data_i;
        bus_o.cs_n <= 1'b1;
        bus_o.rd_n <= 1'b1;
        bus_o.wr_n <= 1'b1;
        oe_o       <= 1'b0;
        repeat (3) @(posedge clock_i);
    endtask : acc
endmodule : shp_host_model

// ===== dv/shp_host_port_tb.sv
// shp_host_port_tb.sv - self-checking bench of the host port
// assumes: register memory resets to zero; host model drives the pins
`include "shp_params.svh"
module shp_host_port_tb
    import shp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [4:0] BT_IDX = 5'h19; // wake target word, arbitrary
    logic                      clock    = 1'b0;
    logic                      rst_b    = 1'b0;
    logic                      sleep_rq = 1'b0;
    logic [`SHP_WW-1:0]        rx_word  = 32'hCAFE_BEEF;
    logic [`SHP_IRQ_SRC_W-1:0] irq_src  = 8'h00;
    logic [`SHP_HW-1:0]        d_o, d_in, r;
    logic                      d_oe, h_oe, rx_pop, tx_push, wake;
    logic                      asleep, irq, irq_oe;
    logic [`SHP_WW-1:0]        tx_word, tx_seen;
    shp_bus_t                  hb;
    int                        fail_count = 0;
    int                        n_tests = 0;
    int                        n_push = 0;
    int                        n_pop = 0;
    int                        n_wake = 0;
    always #25 clock = ~clock;
    // released bus shows the inverse of the last host value
    assign d_in = h_oe ? hb.data : (d_oe ? d_o : ~hb.data);
    shp_host_model host_u (.clock_i(clock), .data_i(d_in), .bus_o(hb),
                           .oe_o(h_oe));
    shp_host_port dut_u (.clock_i(clock), .rst_b_i(rst_b),
        .port_select_n_i(hb.cs_n), .read_strobe_n_i(hb.rd_n),
        .write_strobe_n_i(hb.wr_n), .queue_select_i(hb.qsel),
        .addr_i(hb.addr), .data_i(d_in), .data_o(d_o), .data_oe_o(d_oe),
        .sleep_req_i(sleep_rq), .rx_word_i(rx_word), .irq_src_i(irq_src),
        .rx_pop_o(rx_pop), .tx_push_o(tx_push), .tx_word_o(tx_word),
        .wake_o(wake), .asleep_o(asleep), .irq_o(irq), .irq_oe_o(irq_oe));
    // count one-cycle pulses as they stand
    always @(posedge clock) begin
        if (tx_push === 1'b1) tx_seen = tx_word;
        if (tx_push === 1'b1) n_push++;
        if (rx_pop === 1'b1) n_pop++;
        if (wake === 1'b1) n_wake++;
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wr32(input logic q, input logic [4:0] i,
                        input logic [31:0] v);
        host_u.acc(1'b1, q, {q, i, 1'b0}, v[15:0], r);
        host_u.acc(1'b1, q, {q, i, 1'b1}, v[31:16], r);
    endtask : wr32
    task automatic rd32(input logic q, input logic [4:0] i,
                        output logic [31:0] v);
        host_u.acc(1'b0, q, {q, i, 1'b0}, 16'h0000, v[15:0]);
        host_u.acc(1'b0, q, {q, i, 1'b1}, 16'h0000, v[31:16]);
    endtask : rd32
    task automatic t_reg;
        logic [31:0] v;
        wr32(1'b0, 5'h03, 32'h1234_5678);
        rd32(1'b0, 5'h03, v);
        chk("reg3 unarmed", 32'h0000_0000, v);
        wr32(1'b0, 5'h03, 32'h1234_5678);
        rd32(1'b0, 5'h03, v);
        chk("reg3", 32'h1234_5678, v);
    endtask : t_reg
    task automatic t_queue;
        logic [31:0] v;
        wr32(1'b1, 5'h1F, 32'h1111_2222);
        chk("tx word", 32'h1111_2222, tx_seen);
        chk("tx pushes", 32'h1, n_push);
        rd32(1'b1, 5'h1F, v);
        repeat (3) @(posedge clock);
        chk("rx word", 32'hCAFE_BEEF, v);
        chk("rx pops", 32'h1, n_pop);
    endtask : t_queue
    task automatic t_sleep;
        logic [31:0] v;
        sleep_rq <= 1'b1;
        repeat (6) @(posedge clock);
        chk("asleep", 32'h1, asleep);
        sleep_rq <= 1'b0;
        host_u.acc(1'b1, 1'b0, {1'b0, BT_IDX, 1'b0}, 16'h0000, r);
        chk("wakes", 32'h1, n_wake);
        chk("awake", 32'h0, asleep);
        wr32(1'b0, 5'h05, 32'hA5A5_5A5A);
        rd32(1'b0, 5'h05, v);
        chk("reg5 unarmed", 32'h0000_0000, v);
    endtask : t_sleep
    task automatic t_irq;
        wr32(1'b0, 5'h17, 32'h0000_0001);
        irq_src <= 8'h01;
        repeat (4) @(posedge clock);
        chk("irq active low", 32'h0, irq);
        wr32(1'b0, 5'h15, 32'h0000_0011);
        chk("irq active high", 32'h1, irq);
        chk("irq od drive", 32'h1, irq_oe);
        irq_src <= 8'h00;
        repeat (4) @(posedge clock);
        chk("irq od release", 32'h0, irq_oe);
    endtask : t_irq
    task automatic wrap_up;
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    // main sequence; reset held six cycles
    initial begin
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        t_reg();
        t_queue();
        t_sleep();
        t_irq();
        wrap_up();
    end
    // watchdog: runs need well under 1000 cycles
    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end
endmodule : shp_host_port_tb
bind shp_host_port shp_host_port_asserts chk_u (.clock_i(clock_i),
    .rst_b_i(rst_b_i), .port_select_n_i(port_select_n_i),
    .read_strobe_n_i(read_strobe_n_i), .write_strobe_n_i(write_strobe_n_i),
    .queue_select_i(queue_select_i), .data_oe_o(data_oe_o),
    .tx_push_o(tx_push_o), .rx_pop_o(rx_pop_o), .wake_o(wake_o),
    .asleep_o(asleep_o));
